// File: i2c_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Bus controller model
// ----------------------------------------------------------------------

module i2c_ctrl_model (
  output logic scl,
  output logic pull_low,
  input wire logic sda
);
  // Idle bus: both lines released, held high by the pull-ups.
  initial begin
    scl = 1'h1;
    pull_low = 1'h0;
  end

  // Start or repeated start; from a low clock the data line is raised first.
  task automatic start();
    if (!scl) begin
      #20 pull_low = 1'h0;
      #20 scl = 1'h1;
    end
    #20 pull_low = 1'h1;
    #20 scl = 1'h0;
  endtask

  // Stop: data rises while the clock is high, which frees the bus.
  task automatic stop();
    #20 pull_low = 1'h1;
    #20 scl = 1'h1;
    #20 pull_low = 1'h0;
    #20;
  endtask

  // One bit slot: data set in the low half, sampled in the high half.
  task automatic bit_io(input logic b, output logic r);
    #20 pull_low = ~b;
    #20 scl = 1'h1;
    #20 r = sda;
    #20 scl = 1'h0;
  endtask

  // Eight bits MSB first, then the acknowledge slot (a = 1 releases it).
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack);
  endtask
endmodule

`default_nettype wire

// File: led_i2c_pkg.sv
`default_nettype none

package led_i2c_pkg;

  // Fixed upper part of the strap-selected target address.
  localparam logic [4:0] ADDR_FIXED_HIGH = 5'h05;
  // Broadcast target address answered whatever the straps say.
  localparam logic [6:0] ADDR_BROADCAST = 7'h0c;
  // Direction bit value that asks for a read.
  localparam logic DIR_READ = 1'h1;
  // Bit slot numbers within one byte frame.
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST_DATA = 4'h7;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [3:0] SLOT_STEP = 4'h1;
  // Pointer step applied by auto-increment.
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // Protocol states, Gray coded along the write path IDLE, ADDR, PTR, WDATA.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_PTR = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_SKIP = 3'h7
  } state_type;

  // One register write toward the register file.
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

endpackage

`default_nettype wire

// File: led_i2c_target.sv
// Summary of operation
// - Data line changes only while clock low.
// - Detect start and stop while clock high.
// - Repeated start handled like first start.
// - Eight bits, MSB first, then acknowledge.
// - Pull data low on ninth clock.
// - First byte: seven address bits plus direction.
// - Independent address 00101 plus two strap pins.
// - Also answer broadcast address 0001100.
// - Serve reads to broadcast address too.
// - Acknowledge address only on a match.
// - Write: pointer byte, then data bytes.
// - Advance pointer after each written byte.
// - Read follows pointer write and repeated start.
// - Controller acknowledge advances pointer; nack ends.
// - Auto-increment on at reset, can disable; here the auto_incr_en pin sets it, with no reset value.
// - Pointer spans the full 8-bit space.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Input synchroniser
// ----------------------------------------------------------------------

module in_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic s1_r, s2_r, s3_r, out_r, out_nxt;

  // The output follows only once the second and third stages agree.
  always_comb begin
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  // The first stage feeds the second stage only.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_r <= 1'h1;
      s2_r <= 1'h1;
      s3_r <= 1'h1;
      out_r <= 1'h1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule

// ----------------------------------------------------------------------
// Target port
// ----------------------------------------------------------------------

module led_i2c_target (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_link,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_drive_n,
  input wire logic addr_strap_high,
  input wire logic addr_strap_low,
  input wire logic auto_incr_en,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output led_i2c_pkg::reg_write_type reg_wr,
  output logic bus_busy
);

  // --------------------------------------------------------------------
  // Link domain: bit capture on the serial clock
  // --------------------------------------------------------------------

  logic frame_clr_r;
  logic link_reset;
  logic [3:0] l_cnt_r, l_cnt_nxt;
  logic [7:0] l_shift_r, l_shift_nxt;
  logic l_ack_r, l_ack_nxt;
  logic l_byte_tgl_r, l_byte_tgl_nxt;
  logic l_ack_tgl_r, l_ack_tgl_nxt;

  // Start and stop restart the bit counter so that every frame begins at bit 7.
  assign link_reset = reset | frame_clr_r;

  // Eight data bits are shifted in MSB first, the ninth is the acknowledge.
  always_comb begin
    l_cnt_nxt = l_cnt_r;
    l_shift_nxt = l_shift_r;
    l_ack_nxt = l_ack_r;
    if (l_cnt_r == led_i2c_pkg::SLOT_ACK) begin
      l_ack_nxt = sda_in;
      l_cnt_nxt = led_i2c_pkg::SLOT_FIRST;
    end else begin
      l_shift_nxt = {l_shift_r[6:0], sda_in};
      l_cnt_nxt = l_cnt_r + led_i2c_pkg::SLOT_STEP;
    end
  end

  // Frame counter and shifter registers.
  always_ff @(posedge scl_link or posedge link_reset) begin
    if (link_reset) begin
      l_cnt_r <= led_i2c_pkg::SLOT_FIRST;
      l_shift_r <= 8'h00;
      l_ack_r <= 1'h1;
    end else begin
      l_cnt_r <= l_cnt_nxt;
      l_shift_r <= l_shift_nxt;
      l_ack_r <= l_ack_nxt;
    end
  end

  // Event toggles rest high like the synchronisers and survive start and stop.
  always_comb begin
    l_byte_tgl_nxt = l_byte_tgl_r ^ (l_cnt_r == led_i2c_pkg::SLOT_LAST_DATA);
    l_ack_tgl_nxt = l_ack_tgl_r ^ (l_cnt_r == led_i2c_pkg::SLOT_ACK);
  end

  // Toggle registers.
  always_ff @(posedge scl_link or posedge reset) begin
    if (reset) begin
      l_byte_tgl_r <= 1'h1;
      l_ack_tgl_r <= 1'h1;
    end else begin
      l_byte_tgl_r <= l_byte_tgl_nxt;
      l_ack_tgl_r <= l_ack_tgl_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Crossings into the core clock
  // --------------------------------------------------------------------

  logic [5:0] sync_in, sync_out;
  logic scl_f, sda_f, strap_hi_f, strap_lo_f, byte_tgl_s, ack_tgl_s;

  assign sync_in = {scl_link, sda_in, addr_strap_high, addr_strap_low,
                    l_byte_tgl_r, l_ack_tgl_r};

  // The clock, data and strap pins and both toggles each pass their own three-stage synchroniser; auto_incr_en is used unsynchronised.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      in_sync u_sync (
        .clk(clk),
        .reset(reset),
        .din(sync_in[gi]),
        .dout(sync_out[gi])
      );
    end
  endgenerate

  assign {scl_f, sda_f, strap_hi_f, strap_lo_f, byte_tgl_s, ack_tgl_s} = sync_out;

  // --------------------------------------------------------------------
  // Core: conditions, addressing, pointer and line drive
  // --------------------------------------------------------------------

  led_i2c_pkg::state_type state_r, state_nxt;
  logic scl_p_r, sda_p_r, byte_last_r, ack_last_r;
  logic [3:0] slot_r, slot_nxt;
  logic [7:0] ptr_r, ptr_nxt, tx_r, tx_nxt;
  logic ack_pend_r, ack_pend_nxt, inc_pend_r, inc_pend_nxt, load_r, load_nxt;
  logic drive_n_r, drive_n_nxt, busy_r, busy_nxt;
  led_i2c_pkg::reg_write_type wr_r, wr_nxt;
  logic start_det, stop_det, scl_fall, byte_evt, ack_evt, addr_match, pull_low;
  logic [6:0] addr_indep;

  // Start and stop are data edges seen while the clock stays high.
  assign start_det = scl_f & scl_p_r & sda_p_r & ~sda_f;
  assign stop_det = scl_f & scl_p_r & ~sda_p_r & sda_f;
  assign scl_fall = scl_p_r & ~scl_f;
  assign byte_evt = byte_tgl_s ^ byte_last_r;
  assign ack_evt = ack_tgl_s ^ ack_last_r;

  // Strap levels complete the independent address, high pin first.
  assign addr_indep = {led_i2c_pkg::ADDR_FIXED_HIGH, strap_hi_f, strap_lo_f};
  assign addr_match = (l_shift_r[7:1] == addr_indep) ||
                      (l_shift_r[7:1] == led_i2c_pkg::ADDR_BROADCAST);

  // Next-state logic for the protocol engine.
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    ptr_nxt = ptr_r;
    tx_nxt = tx_r;
    ack_pend_nxt = ack_pend_r;
    inc_pend_nxt = inc_pend_r;
    load_nxt = 1'h0;
    busy_nxt = busy_r;
    wr_nxt = '0;
    wr_nxt.addr = wr_r.addr;
    wr_nxt.data = wr_r.data;
    if (start_det) begin
      // Parking at the ack slot makes the start's own clock fall open bit 7.
      state_nxt = led_i2c_pkg::ST_ADDR;
      slot_nxt = led_i2c_pkg::SLOT_ACK;
      ack_pend_nxt = 1'h0;
      inc_pend_nxt = 1'h0;
      busy_nxt = 1'h1;
    end else if (stop_det) begin
      state_nxt = led_i2c_pkg::ST_IDLE;
      ack_pend_nxt = 1'h0;
      inc_pend_nxt = 1'h0;
      busy_nxt = 1'h0;
    end else begin
      if (byte_evt) begin
        case (state_r)
          led_i2c_pkg::ST_ADDR: begin
            if (addr_match) begin
              ack_pend_nxt = 1'h1;
              state_nxt = (l_shift_r[0] == led_i2c_pkg::DIR_READ) ?
                          led_i2c_pkg::ST_RDATA : led_i2c_pkg::ST_PTR;
            end else begin
              state_nxt = led_i2c_pkg::ST_SKIP;
            end
          end
          led_i2c_pkg::ST_PTR: begin
            ptr_nxt = l_shift_r;
            ack_pend_nxt = 1'h1;
            state_nxt = led_i2c_pkg::ST_WDATA;
          end
          led_i2c_pkg::ST_WDATA: begin
            wr_nxt.en = 1'h1;
            wr_nxt.addr = ptr_r;
            wr_nxt.data = l_shift_r;
            ack_pend_nxt = 1'h1;
            inc_pend_nxt = auto_incr_en;
          end
          default: begin
          end
        endcase
      end
      // The controller's answer to a byte that we sent.
      if (ack_evt && state_r == led_i2c_pkg::ST_RDATA && !ack_pend_r) begin
        if (!l_ack_r) begin
          inc_pend_nxt = auto_incr_en;
        end else begin
          state_nxt = led_i2c_pkg::ST_SKIP;
        end
      end
      if (scl_fall) begin
        if (slot_r == led_i2c_pkg::SLOT_ACK) begin
          slot_nxt = led_i2c_pkg::SLOT_FIRST;
          ack_pend_nxt = 1'h0;
          inc_pend_nxt = 1'h0;
          if (inc_pend_r) begin
            ptr_nxt = ptr_r + led_i2c_pkg::PTR_STEP;
          end
          load_nxt = (state_nxt == led_i2c_pkg::ST_RDATA);
        end else begin
          slot_nxt = slot_r + led_i2c_pkg::SLOT_STEP;
        end
      end
    end
    if (load_r) begin
      tx_nxt = rd_data;
    end
  end

  // The line is pulled low for our acknowledge or for a zero data bit.
  always_comb begin
    pull_low = (slot_r == led_i2c_pkg::SLOT_ACK) && ack_pend_r;
    if (state_r == led_i2c_pkg::ST_RDATA && slot_r != led_i2c_pkg::SLOT_ACK &&
        !ack_pend_r) begin
      pull_low = ~tx_r[3'(led_i2c_pkg::SLOT_LAST_DATA - slot_r)];
    end
    drive_n_nxt = ~pull_low;
    if (state_nxt == led_i2c_pkg::ST_SKIP || state_nxt == led_i2c_pkg::ST_IDLE) begin
      drive_n_nxt = 1'h1;
    end
  end

  // Core registers; drive only changes after a seen clock fall.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= led_i2c_pkg::ST_IDLE;
      scl_p_r <= 1'h1;
      sda_p_r <= 1'h1;
      byte_last_r <= 1'h1;
      ack_last_r <= 1'h1;
      slot_r <= led_i2c_pkg::SLOT_ACK;
      ptr_r <= led_i2c_pkg::PTR_RESET;
      tx_r <= 8'hff;
      ack_pend_r <= 1'h0;
      inc_pend_r <= 1'h0;
      load_r <= 1'h0;
      drive_n_r <= 1'h1;
      busy_r <= 1'h0;
      wr_r <= '0;
      frame_clr_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      scl_p_r <= scl_f;
      sda_p_r <= sda_f;
      byte_last_r <= byte_tgl_s;
      ack_last_r <= ack_tgl_s;
      slot_r <= slot_nxt;
      ptr_r <= ptr_nxt;
      tx_r <= tx_nxt;
      ack_pend_r <= ack_pend_nxt;
      inc_pend_r <= inc_pend_nxt;
      load_r <= load_nxt;
      drive_n_r <= scl_f ? drive_n_r : drive_n_nxt;
      busy_r <= busy_nxt;
      wr_r <= wr_nxt;
      frame_clr_r <= start_det | stop_det;
    end
  end

  assign sda_out = 1'h0;
  assign sda_drive_n = drive_n_r;
  assign rd_addr = ptr_r;
  assign reg_wr = wr_r;
  assign bus_busy = busy_r;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------

  sequence ack_end_s;
    scl_fall && !start_det && !stop_det && slot_r == led_i2c_pkg::SLOT_ACK;
  endsequence

  start_to_addr_a: assert property (@(posedge clk) disable iff (reset)
    start_det |=> state_r == led_i2c_pkg::ST_ADDR && busy_r)
    else $error("start did not open an address phase");
  stop_to_idle_a: assert property (@(posedge clk) disable iff (reset)
    stop_det |=> state_r == led_i2c_pkg::ST_IDLE && !busy_r)
    else $error("stop did not free the bus");
  miss_to_skip_a: assert property (@(posedge clk) disable iff (reset)
    byte_evt && !start_det && !stop_det && state_r == led_i2c_pkg::ST_ADDR && !addr_match
    |=> state_r == led_i2c_pkg::ST_SKIP && !ack_pend_r)
    else $error("mismatched address was accepted");
  hit_acked_a: assert property (@(posedge clk) disable iff (reset)
    byte_evt && !start_det && !stop_det && state_r == led_i2c_pkg::ST_ADDR && addr_match
    |=> ack_pend_r)
    else $error("matching address not acknowledged");
  skip_release_a: assert property (@(posedge clk) disable iff (reset)
    state_r == led_i2c_pkg::ST_SKIP |=> sda_drive_n)
    else $error("line driven after mismatch");
  line_stable_a: assert property (@(posedge clk) disable iff (reset)
    scl_f && scl_p_r |=> $stable(sda_drive_n))
    else $error("data line changed while clock high");
  ack_low_a: assert property (@(posedge clk) disable iff (reset)
    (!scl_f && slot_r == led_i2c_pkg::SLOT_ACK && ack_pend_r)[*2] |-> !sda_drive_n)
    else $error("acknowledge not driven low");
  write_strobe_a: assert property (@(posedge clk) disable iff (reset)
    byte_evt && !start_det && !stop_det && state_r == led_i2c_pkg::ST_WDATA
    |=> reg_wr.en && reg_wr.addr == $past(ptr_r) && reg_wr.data == $past(l_shift_r))
    else $error("data byte not written at the pointer");
  ptr_step_a: assert property (@(posedge clk) disable iff (reset)
    ack_end_s ##0 inc_pend_r |=> ptr_r == 8'($past(ptr_r) + led_i2c_pkg::PTR_STEP))
    else $error("pointer did not advance by one");
  ptr_hold_a: assert property (@(posedge clk) disable iff (reset)
    ack_end_s ##0 !inc_pend_r && !byte_evt |=> $stable(ptr_r))
    else $error("pointer moved with increment off");

endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------------

module testbench;
  logic clk, reset, scl, pull_low, sda, strap_hi, strap_lo, incr_en, ack;
  logic sda_out, sda_drive_n, bus_busy;
  logic [7:0] rd_addr, q;
  logic [7:0] mem [256];
  logic [7:0] exp_mem [256];
  logic [15:0] wq [$];
  led_i2c_pkg::reg_write_type reg_wr;
  int errors, n_compared, cycles;

  // Open-drain data line with a pull-up; either party may pull it low.
  assign sda = ~pull_low & (sda_drive_n | sda_out);

  led_i2c_target i_dut (
    .clk(clk), .reset(reset), .scl_link(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_drive_n(sda_drive_n),
    .addr_strap_high(strap_hi), .addr_strap_low(strap_lo),
    .auto_incr_en(incr_en), .rd_addr(rd_addr), .rd_data(mem[rd_addr]),
    .reg_wr(reg_wr), .bus_busy(bus_busy)
  );

  i2c_ctrl_model i_ctrl (.scl(scl), .pull_low(pull_low), .sda(sda));

  // Core clock, 4 ns period.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Register file beside the port; write pulses are taken on the falling edge, clear of launch.
  always @(negedge clk) begin
    if (reg_wr.en === 1'h1) begin
      mem[reg_wr.addr] <= reg_wr.data;
      wq.push_back({reg_wr.addr, reg_wr.data});
    end
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Independent address for the present strap levels.
  function automatic logic [6:0] own_addr();
    return {5'h05, strap_hi, strap_lo};
  endfunction

  // Lets the port see the stop, then checks the bus is free again.
  task automatic end_frame();
    i_ctrl.stop();
    repeat (10) @(negedge clk);
    check("idle busy", 8'(bus_busy), 8'h00);
    check("stray writes", 8'(wq.size()), 8'h00);
  endtask

  // Write burst from pointer p; every byte must be acknowledged and stored.
  task automatic wr_burst(input logic [6:0] a, input logic [7:0] p, input int n);
    logic [7:0] d;
    logic [15:0] w;
    i_ctrl.start();
    i_ctrl.xfer({a, 1'h0}, 1'h1, q, ack);
    check("addr ack", 8'(ack), 8'h00);
    i_ctrl.xfer(p, 1'h1, q, ack);
    check("ptr ack", 8'(ack), 8'h00);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      i_ctrl.xfer(d, 1'h1, q, ack);
      check("data ack", 8'(ack), 8'h00);
      w = (wq.size() > 0) ? wq.pop_front() : 16'hxxxx;
      check("wr addr", w[15:8], p);
      check("wr data", w[7:0], d);
      exp_mem[p] = d;
      if (incr_en) p = p + 8'h01;
    end
    end_frame();
    $display("test write burst done");
  endtask

  // Pointer write, repeated start, then n bytes read, the last one refused.
  task automatic rd_burst(input logic [6:0] a, input logic [7:0] p, input int n);
    i_ctrl.start();
    i_ctrl.xfer({a, 1'h0}, 1'h1, q, ack);
    i_ctrl.xfer(p, 1'h1, q, ack);
    i_ctrl.start();
    i_ctrl.xfer({a, 1'h1}, 1'h1, q, ack);
    check("rd addr ack", 8'(ack), 8'h00);
    for (int i = 0; i < n; i++) begin
      i_ctrl.xfer(8'hff, 1'(i == n - 1), q, ack);
      check("rd data", q, exp_mem[p]);
      if (incr_en) p = p + 8'h01;
    end
    end_frame();
    $display("test read burst done");
  endtask

  // Address matching over every strap setting, with a refused address.
  task automatic addr_test();
    logic [6:0] a;
    logic dir;
    for (int s = 0; s < 4; s++) begin
      {strap_hi, strap_lo} = 2'(s);
      repeat (10) @(negedge clk);
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? own_addr() : 7'h0c;
        while (k == 2 && (a == own_addr() || a == 7'h0c)) a = 7'($urandom);
        i_ctrl.start();
        dir = 1'($urandom);
        i_ctrl.xfer({a, dir}, 1'h1, q, ack);
        check("busy", 8'(bus_busy), 8'h01);
        check("addr ack", 8'(ack), 8'(k == 2));
        if (k == 2) begin
          i_ctrl.xfer(8'h00, 1'h1, q, ack);
          check("skip ack", 8'(ack), 8'h01);
        end else if (dir === 1'h1) begin
          // A matched read with no pointer byte serves the reset pointer, then a nack.
          i_ctrl.xfer(8'hff, 1'h1, q, ack);
          check("direct rd", q, exp_mem[8'h00]);
        end
        end_frame();
      end
    end
    $display("test address match done");
  endtask

  // Main sequence.
  initial begin
    logic [7:0] p;
    reset = 1'h1;
    strap_hi = 1'h0;
    strap_lo = 1'h1;
    incr_en = 1'h1;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    void'($urandom(67894));
    repeat (6) @(negedge clk);
    reset = 1'h0;
    check("rst drive", 8'(sda_drive_n), 8'h01);
    check("rst ptr", rd_addr, 8'h00);
    check("rst busy", 8'(bus_busy), 8'h00);
    repeat (8) @(negedge clk);
    #1.3;
    addr_test();
    wr_burst(own_addr(), 8'hfe, 4);
    rd_burst(7'h0c, 8'hfe, 4);
    for (int t = 0; t < 4; t++) begin
      p = 8'($urandom);
      wr_burst(own_addr(), p, 1 + $urandom_range(0, 3));
      rd_burst(own_addr(), p, 1 + $urandom_range(0, 3));
    end
    // Reset again with the bus idle; the pointer must return to zero.
    reset = 1'h1;
    repeat (6) @(negedge clk);
    reset = 1'h0;
    check("rst2 ptr", rd_addr, 8'h00);
    check("rst2 busy", 8'(bus_busy), 8'h00);
    check("rst2 drive", 8'(sda_drive_n), 8'h01);
    repeat (8) @(negedge clk);
    $display("test mid-run reset done");
    incr_en = 1'h0;
    p = 8'($urandom);
    wr_burst(own_addr(), p, 3);
    rd_burst(own_addr(), p, 2);
    finish_test();
  end
endmodule

`default_nettype wire
